// ### verilog/cic_top.sv
// Purpose: interrupt controller for the 8-bit core sequencer
// Assumes: apb slave, single pclk, sources pulse one cycle per event
// Notes: shadow context is captured per take, status less timeout/powerdown, and restored per return
// How it works
// - any reset leaves global enable clear so nothing redirects flow
// - redirect needs own enable and global enable; peripherals also group enable
// - each source latches into its own flag bit in control or peripheral flags, except async, which shares bit 0 with core event 0
// - flags set on events regardless of any enable bit
// - taking flushes prefetch, clears global enable, pushes pc, shadows, vectors 0004h
// - with global enable clear requests only latch; pending served once re-enabled
// - return instruction pops pc, restores shadows and sets global enable
// - synchronous source latency is three or four instruction cycles; a take before the last cycle of a multi-cycle instruction adds two cycles
// - asynchronous source latency is three to five instruction cycles; a take before the last cycle of a multi-cycle instruction adds two cycles
// - enabled sources wake the core from sleep
// - shadow holds accumulator, status less timeout/powerdown, bank, pointers, pc high latch
// - after wake the instruction after sleep runs first, then vector if enabled
`timescale 1ns/1ps
`default_nettype none
module cic_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [2:0] core_event,
	input wire logic [31:0] periph_event,
	input wire logic async_event,
	input wire logic instr_last_cycle,
	input wire logic instr_multi_cycle,
	input wire logic sleep_instr,
	input wire logic return_from_irq_instr,
	input wire logic [14:0] pc_in,
	input wire logic [7:0] acc_in,
	input wire logic [4:0] status_in,
	input wire logic [4:0] bank_select_reg_in,
	input wire logic [31:0] indirect_pointer_regs_in,
	input wire logic [6:0] pc_high_latch_in,
	output logic flush_prefetch,
	output logic force_nop,
	output logic push_pc,
	output logic [14:0] pc_push_value,
	output logic load_pc,
	output logic [14:0] pc_load_value,
	output logic restore_ctx,
	output logic [7:0] acc_out,
	output logic [4:0] status_out,
	output logic [4:0] bank_select_reg_out,
	output logic [31:0] indirect_pointer_regs_out,
	output logic [6:0] pc_high_latch_out,
	output logic core_asleep,
	output logic irq_pending
);
	logic [7:0] irq_control_reg;
	logic [7:0] pflags [4];
	logic [7:0] pens [4];
	logic [7:0] wake_en;
	logic [1:0] phase;
	logic sample_tick;
	logic async_seen;
	logic req_sampled;
	logic [1:0] nop_left;
	cic_pkg::cic_state_t state;
	logic wr;
	logic rd;
	logic [7:0] wbyte;
	logic [31:0] periph_pend;
	logic core_pend;
	logic any_pend;
	logic take;
	logic wake_hit;
	logic gie_clr_take;
	logic gie_set_ret;
	logic wr_ctrl;
	logic wr_wake;
	logic [3:0] wr_pflag;
	logic [3:0] wr_pen;
	logic [7:0] ctrl_base;

	assign wr = psel && penable && pwrite;
	assign rd = psel && !penable && !pwrite;
	assign wbyte = pwdata[7:0];
	assign sample_tick = (phase == cic_pkg::sample_phase);
	assign wr_ctrl = wr && (paddr == cic_pkg::addr_ctrl);
	assign wr_wake = wr && (paddr == cic_pkg::addr_wake_en);
	// software view of the control byte this cycle, before hardware sets and clears
	assign ctrl_base = wr_ctrl ? wbyte : irq_control_reg;

	// phase divider gives one instruction cycle per four pclk
	// phase 0 is the request sample point; the other phases let flags settle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= 2'h0;
		end else begin
			phase <= phase + 2'h1;
		end
	end

	// async event stretched until the next sample point
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			async_seen <= 1'b0;
		end else if (sample_tick) begin
			async_seen <= async_event;
		end else if (async_event) begin
			async_seen <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_control_reg <= cic_pkg::ctrl_reset;
		end else begin
			irq_control_reg[7:3] <= ctrl_base[7:3];
			if (gie_clr_take) begin
				irq_control_reg[cic_pkg::bit_gie] <= 1'b0;
			end else if (gie_set_ret) begin
				irq_control_reg[cic_pkg::bit_gie] <= 1'b1;
			end
			// an event in the cycle of a clearing write still lands
			irq_control_reg[2:1] <= ctrl_base[2:1] | core_event[2:1];
			// async events come through the stretcher so none slips past a sample point
			irq_control_reg[0] <= ctrl_base[0] | core_event[0] | async_seen;
		end
	end

	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_periph
			assign wr_pflag[g] = wr && (paddr == cic_pkg::addr_pflag_a + 8'(4 * g));
			assign wr_pen[g] = wr && (paddr == cic_pkg::addr_pen_a + 8'(4 * g));
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pflags[g] <= 8'h00;
					pens[g] <= 8'h00;
				end else begin
					pflags[g] <= (wr_pflag[g] ? wbyte : pflags[g]) | periph_event[8*g +: 8];
					if (wr_pen[g]) begin
						pens[g] <= wbyte;
					end
				end
			end
			assign periph_pend[8*g +: 8] = pflags[g] & pens[g];
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_en <= 8'h00;
		end else if (wr_wake) begin
			wake_en <= wbyte;
		end
	end

	assign core_pend = |((irq_control_reg[5:3]) & (irq_control_reg[2:0]));
	assign any_pend = core_pend || (irq_control_reg[cic_pkg::bit_periph_group_enable] && |periph_pend);

	// sample once per icycle
	// the take uses the previous sample, so a flag set mid-cycle waits one tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_sampled <= 1'b0;
		end else if (sample_tick) begin
			req_sampled <= any_pend && irq_control_reg[cic_pkg::bit_gie];
		end
	end

	assign wake_hit = sample_tick && (any_pend || |(wake_en & {5'h00, irq_control_reg[2:0]}));
	assign take = (state == cic_pkg::cic_run_s) && sample_tick && req_sampled && irq_control_reg[cic_pkg::bit_gie];
	assign gie_clr_take = take;
	assign gie_set_ret = (state == cic_pkg::cic_run_s) && sample_tick && return_from_irq_instr;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= cic_pkg::cic_run_s;
			nop_left <= 2'h0;
		end else if (sample_tick) begin
			unique case (state)
				cic_pkg::cic_run_s: begin
					// a take in the last cycle of an instruction skips the finish state
					if (take) begin
						state <= instr_last_cycle ? cic_pkg::cic_nop_s : cic_pkg::cic_finish_s;
						nop_left <= cic_pkg::nop_after_1cyc;
					end else if (sleep_instr) begin
						state <= cic_pkg::cic_sleep_s;
					end
				end

				cic_pkg::cic_finish_s: begin
					// a multi-cycle instruction needs one more forced cycle
					if (instr_last_cycle) begin
						state <= cic_pkg::cic_nop_s;
						nop_left <= instr_multi_cycle ? cic_pkg::nop_after_multi : cic_pkg::nop_after_1cyc;
					end
				end

				cic_pkg::cic_nop_s: begin
					// nop_left counts the forced cycles still to run
					nop_left <= nop_left - 2'h1;
					if (nop_left == 2'h1) begin
						state <= cic_pkg::cic_vector_s;
					end
				end

				cic_pkg::cic_vector_s: state <= cic_pkg::cic_run_s;

				cic_pkg::cic_sleep_s: begin
					if (wake_hit) begin
						state <= cic_pkg::cic_wake_s;
					end
				end

				cic_pkg::cic_wake_s: begin
					state <= cic_pkg::cic_run_s;
				end

				default: state <= cic_pkg::cic_run_s;
			endcase
		end
	end

	// flush and push one pclk after the take tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flush_prefetch <= 1'b0;
			push_pc <= 1'b0;
			pc_push_value <= 15'h0000;
		end else begin
			flush_prefetch <= take;
			push_pc <= take;
			if (take) begin
				pc_push_value <= pc_in;
			end
		end
	end

	// forced no-operation cycles, then the vector load
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			force_nop <= 1'b0;
			load_pc <= 1'b0;
			pc_load_value <= 15'h0000;
		end else begin
			force_nop <= (state == cic_pkg::cic_nop_s) || (state == cic_pkg::cic_finish_s && instr_last_cycle);
			load_pc <= sample_tick && state == cic_pkg::cic_nop_s && nop_left == 2'h1;
			pc_load_value <= cic_pkg::irq_vector;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			restore_ctx <= 1'b0;
		end else begin
			restore_ctx <= gie_set_ret;
		end
	end

	// sleep level seen by the core
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_asleep <= 1'b0;
		end else begin
			core_asleep <= (state == cic_pkg::cic_sleep_s);
		end
	end

	// shadow capture
	// shadows stand between takes; the core reloads them when restore_ctx pulses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_out <= 8'h00;
			status_out <= 5'h00;
			bank_select_reg_out <= 5'h00;
			indirect_pointer_regs_out <= 32'h00000000;
			pc_high_latch_out <= 7'h00;
		end else if (take) begin
			acc_out <= acc_in;
			// timeout and powerdown bits are never shadowed
			status_out <= status_in & cic_pkg::status_save_mask;
			bank_select_reg_out <= bank_select_reg_in;
			indirect_pointer_regs_out <= indirect_pointer_regs_in;
			pc_high_latch_out <= pc_high_latch_in;
		end
	end

	// pending level, not gated by global enable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_pending <= 1'b0;
		end else begin
			irq_pending <= any_pend;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
			pready <= 1'b0;
		end else begin
			pready <= psel && !penable;
			// unmapped or unaligned: error flagged, read gives zero, write finds no target
			if (psel && !penable) begin
				pslverr <= (paddr > cic_pkg::addr_state) || (paddr[1:0] != 2'h0);
			end
			if (rd) begin
				unique case (paddr)
					cic_pkg::addr_ctrl: prdata <= {24'h0, irq_control_reg};
					cic_pkg::addr_pflag_a: prdata <= {24'h0, pflags[0]};
					cic_pkg::addr_pflag_b: prdata <= {24'h0, pflags[1]};
					cic_pkg::addr_pflag_c: prdata <= {24'h0, pflags[2]};
					cic_pkg::addr_pflag_d: prdata <= {24'h0, pflags[3]};
					cic_pkg::addr_pen_a: prdata <= {24'h0, pens[0]};
					cic_pkg::addr_pen_b: prdata <= {24'h0, pens[1]};
					cic_pkg::addr_pen_c: prdata <= {24'h0, pens[2]};
					cic_pkg::addr_pen_d: prdata <= {24'h0, pens[3]};
					cic_pkg::addr_wake_en: prdata <= {24'h0, wake_en};
					cic_pkg::addr_state: prdata <= {27'h0, req_sampled, 1'b0, state};
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // cic_top
`default_nettype wire

// ### include/cic_pkg.sv
// Purpose: constants shared by the cpu interrupt controller
// Assumes: 8-bit core, one instruction cycle = four pclk phases
// Notes: register addresses are byte offsets on apb, one word apart
package cic_pkg;
	localparam int unsigned clk_mhz = 100;
	localparam int unsigned phases_per_icycle = 4;
	localparam logic [1:0] sample_phase = 2'h0;
	localparam logic [14:0] irq_vector = 15'h0004;
	// apb byte addresses
	localparam logic [7:0] addr_ctrl = 8'h00;
	localparam logic [7:0] addr_pflag_a = 8'h04;
	localparam logic [7:0] addr_pflag_b = 8'h08;
	localparam logic [7:0] addr_pflag_c = 8'h0c;
	localparam logic [7:0] addr_pflag_d = 8'h10;
	localparam logic [7:0] addr_pen_a = 8'h14;
	localparam logic [7:0] addr_pen_b = 8'h18;
	localparam logic [7:0] addr_pen_c = 8'h1c;
	localparam logic [7:0] addr_pen_d = 8'h20;
	localparam logic [7:0] addr_wake_en = 8'h24;
	localparam logic [7:0] addr_state = 8'h28;
	// irq_control_reg fields
	localparam int unsigned bit_gie = 7;
	localparam int unsigned bit_periph_group_enable = 6;
	localparam logic [7:0] ctrl_reset = 8'h00;
	localparam logic [7:0] core_en_mask = 8'h38;
	localparam logic [7:0] core_flag_mask = 8'h07;
	localparam logic [4:0] status_save_mask = 5'h07;
	localparam logic [1:0] nop_after_1cyc = 2'h2;
	localparam logic [1:0] nop_after_multi = 2'h3;
	typedef enum logic [2:0] {
		cic_run_s = 3'b000,
		cic_finish_s = 3'b001,
		cic_nop_s = 3'b010,
		cic_vector_s = 3'b011,
		cic_sleep_s = 3'b100,
		cic_wake_s = 3'b101
	} cic_state_t;
endpackage

// ### dv/cic_top_sva.sv
// Purpose: port checks for cic_top
// Assumes: one pclk domain
// Notes: bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module cic_top_sva (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic flush_prefetch,
	input wire logic push_pc,
	input wire logic force_nop,
	input wire logic load_pc,
	input wire logic [14:0] pc_load_value,
	input wire logic restore_ctx,
	input wire logic irq_pending
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence take_s;
		flush_prefetch && push_pc;
	endsequence
	sequence vec_s;
		##[4:20] load_pc;
	endsequence
	quiet_start_a: assert property ($rose(presetn) |-> !irq_pending && !load_pc) else $error("busy after reset");
	take_cause_a: assert property (flush_prefetch |-> $past(irq_pending)) else $error("take without request");
	take_pair_a: assert property (flush_prefetch |-> push_pc) else $error("flush without push");
	vec_addr_a: assert property (load_pc |-> pc_load_value == 15'h0004) else $error("bad vector");
	vec_delay_a: assert property (take_s |-> vec_s) else $error("vector late");
	nop_fill_a: assert property (take_s |-> ##[1:4] force_nop) else $error("no forced nop");
	gie_hold_a: assert property (take_s |=> !flush_prefetch [*8]) else $error("nested take");
	ret_pulse_a: assert property (restore_ctx |=> !restore_ctx) else $error("restore not a pulse");
	apb_ready_a: assert property (psel && penable |-> pready) else $error("no ready");
	apb_refuse_a: assert property (pready && paddr > 8'h28 |-> pslverr) else $error("unmapped accepted");
endmodule // cic_top_sva
bind cic_top cic_top_sva chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
	.pready(pready), .pslverr(pslverr), .flush_prefetch(flush_prefetch), .push_pc(push_pc), .force_nop(force_nop),
	.load_pc(load_pc), .pc_load_value(pc_load_value), .restore_ctx(restore_ctx), .irq_pending(irq_pending));
`default_nettype wire

// ### dv/cic_core_model.sv
// Purpose: behavioural core sequencer beside cic_top
// Assumes: four pclk per instruction cycle
// Notes: slow makes every instruction two cycles long
`timescale 1ns/1ps
`default_nettype none
module cic_core_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic slow,
	input wire logic load_pc,
	input wire logic [14:0] pc_load_value,
	output logic instr_last_cycle,
	output logic instr_multi_cycle,
	output logic [14:0] pc_in
);
	logic [2:0] ph;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ph <= 3'h0;
			pc_in <= 15'h0000;
		end else begin
			ph <= ph + 3'h1;
			if (load_pc)
				pc_in <= pc_load_value;
			else if (ph[1:0] == 2'h3)
				pc_in <= pc_in + 15'h0001;
		end
	end
	assign instr_multi_cycle = slow;
	assign instr_last_cycle = !slow || ph[2];
endmodule // cic_core_model
`default_nettype wire

// ### dv/cic_top_tb.sv
// Purpose: self-checking bench for cic_top
// Assumes: apb answers without wait states
// Notes: expected flags kept in fl
`timescale 1ns/1ps
`default_nettype none
module cic_top_tb;
	logic pclk, presetn, psel, penable, pwrite, async_event, slow, ret, last, multi, sl, err;
	logic [7:0] paddr, acc;
	logic [31:0] pwdata, prdata, r, pev;
	logic [2:0] cev;
	logic [14:0] pc, plv;
	logic [15:0] lf;
	logic pready, pslverr, flush, lpc, rst_ctx;
	logic [7:0] acc_out;
	logic [4:0] stout, bout;
	logic [6:0] phout;
	logic [31:0] iout;
	logic ipend, sli;
	int num_errors, cmp_count, cyc, takes, n, fl[4];
	cic_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .core_event(cev),
		.periph_event(pev), .async_event(async_event), .instr_last_cycle(last), .instr_multi_cycle(multi),
		.sleep_instr(sli), .return_from_irq_instr(ret), .pc_in(pc), .acc_in(acc), .status_in(5'h1f),
		.bank_select_reg_in(5'h03), .indirect_pointer_regs_in(32'h2c5e9a17), .pc_high_latch_in(7'h11),
		.flush_prefetch(flush), .force_nop(), .push_pc(), .pc_push_value(), .load_pc(lpc), .pc_load_value(plv),
		.restore_ctx(rst_ctx), .acc_out(acc_out), .status_out(stout), .bank_select_reg_out(bout),
		.indirect_pointer_regs_out(iout), .pc_high_latch_out(phout), .core_asleep(sl), .irq_pending(ipend));
	cic_core_model core (.pclk(pclk), .presetn(presetn), .slow(slow), .load_pc(lpc), .pc_load_value(plv),
		.instr_last_cycle(last), .instr_multi_cycle(multi), .pc_in(pc));
	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc++;
		if (flush === 1'b1)
			takes++;
		if (cyc == 8000) begin
			num_errors++;
			conclude();
		end
	end
	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wvec;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (lpc !== 1'b1 && n < 40);
	endtask
	// clear the served flag, then return
	task automatic leave(input logic [7:0] a, input logic [31:0] d);
		apb(1, a, d);
		ret <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (rst_ctx !== 1'b1 && n < 60);
		ret <= 0;
	endtask
	task automatic conclude;
		$display("comparisons %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		{presetn, psel, penable, pwrite, async_event, slow, ret, sli, paddr, pwdata, pev, cev} = '0;
		lf = 16'h4061;
		acc = 8'h5a;
		repeat (20) @(posedge pclk);
		presetn <= 1;
		apb(0, cic_pkg::addr_ctrl, 0);
		chk(r, 0);
		cev <= 3'h1;
		@(posedge pclk);
		cev <= 3'h0;
		apb(0, cic_pkg::addr_ctrl, 0);
		chk(r, 32'h01);
		for (int g = 0; g < 4; g++) begin
			lf = nx(lf);
			fl[g] = lf[7:0] | 1;
			pev <= 32'(fl[g]) << (8 * g);
			@(posedge pclk);
			pev <= 0;
			apb(0, cic_pkg::addr_pflag_a + 8'(4 * g), 0);
			chk(r, fl[g]);
			apb(1, cic_pkg::addr_pflag_a + 8'(4 * g), 0);
		end
		apb(1, cic_pkg::addr_ctrl, 32'h09);
		repeat (30) @(posedge pclk);
		chk(takes, 0);
		for (int k = 0; k < 3; k++) begin
			lf = nx(lf);
			acc <= lf[7:0];
			slow <= k[1];
			if (k == 0)
				apb(1, cic_pkg::addr_ctrl, 32'h89);
			else if (k == 1)
				cev <= 3'h1;
			else
				async_event <= 1;
			@(posedge pclk);
			{cev, async_event} <= '0;
			wvec();
			chk(n <= 24, 1);
			chk(plv, 15'h0004);
			chk(takes, k + 1);
			repeat (2) @(posedge pclk);
			chk(acc_out, acc);
			chk(stout, 5'h07);
			chk(bout, 5'h03);
			chk(phout, 7'h11);
			chk(iout, 32'h2c5e9a17);
			apb(0, cic_pkg::addr_ctrl, 0);
			chk(r, 32'h09);
			leave(cic_pkg::addr_ctrl, 32'h08);
			apb(0, cic_pkg::addr_ctrl, 0);
			chk(r, 32'h88);
		end
		apb(1, cic_pkg::addr_pen_a, 32'hff);
		pev <= 32'h1;
		@(posedge pclk);
		pev <= 0;
		repeat (30) @(posedge pclk);
		chk(takes, 3);
		chk(ipend, 0);
		apb(1, cic_pkg::addr_ctrl, 32'hc0);
		wvec();
		chk(takes, 4);
		chk(ipend, 1);
		// poll the flags to find the source
		apb(0, cic_pkg::addr_pflag_a, 0);
		chk(r, 32'h01);
		leave(cic_pkg::addr_pflag_a, 0);
		repeat (40) @(posedge pclk);
		chk(takes, 4);
		apb(1, cic_pkg::addr_ctrl, 32'h08);
		sli <= 1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (sl !== 1'b1 && n < 20);
		sli <= 0;
		chk(sl, 1);
		repeat (12) @(posedge pclk);
		chk(sl, 1);
		cev <= 3'h1;
		@(posedge pclk);
		cev <= 3'h0;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (sl !== 1'b0 && n < 20);
		chk(sl, 0);
		repeat (20) @(posedge pclk);
		chk(takes, 4);
		apb(0, 8'h2c, 0);
		chk(err, 1);
		chk(r, 0);
		conclude();
	end
endmodule // cic_top_tb
`default_nettype wire
